// ### src/iop4_pkg.sv
package iop4_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_DATA   = 16'hffd7;
  localparam logic [15:0] IDX_DIR    = 16'hffe7;
  localparam logic [15:0] IDX_P3_PU  = 16'hffd0;
  localparam int          ADDR_W     = 18;
  localparam logic [ADDR_W-1:0] ADDR_DATA  = ADDR_W'({IDX_DATA, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_DIR   = ADDR_W'({IDX_DIR, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_P3_PU = ADDR_W'({IDX_P3_PU, 2'b00});

  // reset values and read patterns
  localparam logic [7:0] DATA_RST   = 8'hf8;
  localparam logic [7:0] DIR_RST    = 8'hf8;
  localparam logic [7:0] DIR_READ   = 8'hff;
  localparam logic [7:0] P3_PU_RST  = 8'h00;
  localparam logic [3:0] DATA_UPPER = 4'hf;

  // field positions of the port
  localparam int BIT_CLK  = 0;
  localparam int BIT_RX   = 1;
  localparam int BIT_TX   = 2;
  localparam int BIT_IRQ  = 3;
  localparam int GPIO_W   = 3;
  localparam int P3_W     = 8;
  localparam int BIT_P3_FLASH_PU = 2;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // power modes seen by the pins
  typedef enum logic [2:0] {
    MODE_ACTIVE    = 3'b000,
    MODE_SUBACTIVE = 3'b001,
    MODE_SLEEP     = 3'b010,
    MODE_SUBSLEEP  = 3'b011,
    MODE_WATCH     = 3'b100,
    MODE_STANDBY   = 3'b101,
    MODE_RESET     = 3'b110
  } iop4_mode_t;

endpackage

// ### src/iop4_pin_state.sv
`timescale 1ns/1ps
// applies the power-mode pin behaviour to a group of pads
module iop4_pin_state import iop4_pkg::*; #(
  parameter int         W      = 8,
  parameter logic [W-1:0] RST_PU = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // mode and functional request
  input  wire iop4_mode_t   mode,
  input  wire logic [W-1:0] func_out,
  input  wire logic [W-1:0] func_oe,
  input  wire logic [W-1:0] func_pu,
  // registered pad controls
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe,
  output logic      [W-1:0] pad_pu
);

  // pads float in reset, hold in the low-power clock-stopped modes
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pad_out <= '0;
      pad_oe  <= '0;
      pad_pu  <= RST_PU; // see R2
    end else begin
      case (mode)
        MODE_ACTIVE, MODE_SUBACTIVE: begin // see R1
          pad_out <= func_out;
          pad_oe  <= func_oe;
          pad_pu  <= func_pu;
        end
        MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH: begin // see R1
          pad_out <= pad_out;
          pad_oe  <= pad_oe;
          pad_pu  <= pad_pu;
        end
        MODE_STANDBY: begin
          // a pulled-up pad is driven high so it does not float, see R16
          pad_out <= func_pu;
          pad_oe  <= func_pu;
          pad_pu  <= func_pu;
        end
        MODE_RESET: begin
          pad_out <= '0;
          pad_oe  <= '0;
          pad_pu  <= RST_PU; // see R2
        end
        default: begin
          pad_out <= '0;
          pad_oe  <= '0;
          pad_pu  <= '0;
        end
      endcase
    end
  end

endmodule // iop4_pin_state

// ### src/iop4_port.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// R1 - neighbour pins float in reset, and in standby unless pulled up; hold in sleep/watch, work when active.
// R2 - flash build pulls up neighbour bit 2 in reset; mask build floats it.
// R3 - outside reset, pull-up on only when direction is 0 and pull-up enable is 1.
// R4 - every neighbour pull-up is off after reset.
// R5 - bits 2..0 bidirectional, bit 3 input only and read-only.
// R6 - data latch resets to F8; unused upper bits read as one.
// R7 - reading returns latch for output pins, pin level for input pins.
// R8 - direction bit 1 makes an output, 0 an input.
// R9 - direction register resets to F8, all three pins inputs.
// R10 - direction register is write-only and reads all ones.
// R11 - direction and data act only while the serial channel leaves the pin.
// R12 - bit 3 is plain input, or external interrupt 0 when selected.
// R13 - bit 2 is transmit output when pin-select and transmit enable are set.
// R14 - bit 1 is receive input when receive enable is set.
// R15 - bit 0 clock in on high select, clock out on low select or sync.
// R16 - in standby a pulled-up neighbour pin drives high.
// R17 - writes to reserved bits are ignored; those bits read as one.
module iop4_port import iop4_pkg::*; #(
  parameter bit FLASH_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // power mode from the system controller
  input  wire iop4_mode_t        power_mode,
  // serial channel pin controls
  input  wire logic              serial_two_pin_select,
  input  wire logic              serial_two_tx_enable,
  input  wire logic              serial_two_rx_enable,
  input  wire logic              serial_two_clock_sel_high,
  input  wire logic              serial_two_clock_sel_low,
  input  wire logic              serial_two_sync_mode,
  input  wire logic              serial_two_tx_pin,
  input  wire logic              serial_two_clock_out,
  output logic                   serial_two_rx_pin,
  output logic                   serial_two_clock_in,
  // interrupt pin selection
  input  wire logic              ext_interrupt_zero_select,
  output logic                   ext_interrupt_zero_in,
  // port four pads
  input  wire logic [3:0]        p4_pin_in,
  output logic      [3:0]        p4_pin_out,
  output logic      [3:0]        p4_pin_oe,
  // neighbouring port pads
  input  wire logic [P3_W-1:0]   port_three_direction,
  input  wire logic [P3_W-1:0]   p3_func_out,
  output logic      [P3_W-1:0]   p3_pin_out,
  output logic      [P3_W-1:0]   p3_pin_oe,
  output logic      [P3_W-1:0]   p3_pullup_on
);

  // register state
  logic [GPIO_W-1:0] data_q;
  logic [GPIO_W-1:0] dir_q;
  logic [P3_W-1:0]   p3_pu_en_q;
  // bus state
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic              w_lane0_q;
  logic              wr_fire;
  // pin function selects
  logic              tx_sel;
  logic              rx_sel;
  logic              ck_in_sel;
  logic              ck_out_sel;
  logic [GPIO_W-1:0] gpio_sel;
  logic [3:0]        p4_out_d;
  logic [3:0]        p4_oe_d;
  logic [P3_W-1:0]   p3_pu_d;
  logic [7:0]        port_read;

  // word-aligned address match, shared by write and read decode
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] reg_addr);
    addr_is = (a[ADDR_W-1:2] == reg_addr[ADDR_W-1:2]);
  endfunction

  // serial functions claim their pin before the port registers do
  assign tx_sel     = serial_two_pin_select & serial_two_tx_enable; // see R13
  assign rx_sel     = serial_two_rx_enable; // see R14
  assign ck_in_sel  = serial_two_clock_sel_high; // see R15
  assign ck_out_sel = ~serial_two_clock_sel_high &
                      (serial_two_clock_sel_low | serial_two_sync_mode); // see R15
  assign gpio_sel   = {~tx_sel, ~rx_sel, ~(ck_in_sel | ck_out_sel)}; // see R11

  // pad drive; bit 3 is never driven because it is an input-only pin
  always_comb begin
    p4_out_d = '0;
    p4_oe_d  = '0;
    for (int i = 0; i < GPIO_W; i++) begin
      p4_out_d[i] = data_q[i];
      p4_oe_d[i]  = gpio_sel[i] & dir_q[i]; // see R8
    end
    if (tx_sel) begin
      p4_out_d[BIT_TX] = serial_two_tx_pin; // see R13
      p4_oe_d[BIT_TX]  = 1'b1;
    end
    if (ck_out_sel) begin
      p4_out_d[BIT_CLK] = serial_two_clock_out; // see R15
      p4_oe_d[BIT_CLK]  = 1'b1;
    end
    p4_oe_d[BIT_IRQ] = 1'b0; // see R5
  end

  // read view: output pins show the latch, inputs show the pad
  always_comb begin
    port_read = {DATA_UPPER, p4_pin_in[BIT_IRQ], {GPIO_W{1'b0}}}; // see R5 R17
    for (int i = 0; i < GPIO_W; i++) begin
      port_read[i] = dir_q[i] ? data_q[i] : p4_pin_in[i]; // see R7
    end
  end

  // neighbour pull-ups need an input pin and the enable bit
  assign p3_pu_d = ~port_three_direction & p3_pu_en_q; // see R3

  // pad power-mode cells
  iop4_pin_state #(
    .W      (4),
    .RST_PU (4'h0)
  ) u_p4_state (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .mode     (power_mode),
    .func_out (p4_out_d),
    .func_oe  (p4_oe_d),
    .func_pu  (4'h0),
    .pad_out  (p4_pin_out),
    .pad_oe   (p4_pin_oe),
    .pad_pu   ()
  );

  iop4_pin_state #(
    .W      (P3_W),
    .RST_PU (FLASH_VARIANT ? P3_W'(1 << BIT_P3_FLASH_PU) : P3_W'(0)) // see R2
  ) u_p3_state (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .mode     (power_mode),
    .func_out (p3_func_out),
    .func_oe  (port_three_direction),
    .func_pu  (p3_pu_d),
    .pad_out  (p3_pin_out),
    .pad_oe   (p3_pin_oe),
    .pad_pu   (p3_pullup_on)
  );

  // serial and interrupt inputs are registered copies of the pads
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      serial_two_rx_pin     <= 1'b1;
      serial_two_clock_in   <= 1'b1;
      ext_interrupt_zero_in <= 1'b1;
    end else begin
      serial_two_rx_pin     <= rx_sel ? p4_pin_in[BIT_RX] : 1'b1; // see R14
      serial_two_clock_in   <= ck_in_sel ? p4_pin_in[BIT_CLK] : 1'b1; // see R15
      // deselected pin reads as idle high so the interrupt logic sees no edge
      ext_interrupt_zero_in <= ext_interrupt_zero_select ? p4_pin_in[BIT_IRQ] : 1'b1; // see R12
    end
  end

  // write address and data are taken independently, in either order
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_lane0_q     <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_lane0_q    <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (addr_is(aw_addr_q, ADDR_DATA) || addr_is(aw_addr_q, ADDR_DIR) ||
                         addr_is(aw_addr_q, ADDR_P3_PU)) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

  // register writes; only the low lane carries register bits
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      data_q     <= DATA_RST[GPIO_W-1:0]; // see R6
      dir_q      <= DIR_RST[GPIO_W-1:0]; // see R9
      p3_pu_en_q <= P3_PU_RST; // see R4
    end else if (wr_fire && w_lane0_q) begin
      // reserved bits are simply not stored
      if (addr_is(aw_addr_q, ADDR_DATA)) data_q <= w_data_q[GPIO_W-1:0]; // see R17
      if (addr_is(aw_addr_q, ADDR_DIR))  dir_q  <= w_data_q[GPIO_W-1:0]; // see R8 R17
      if (addr_is(aw_addr_q, ADDR_P3_PU)) p3_pu_en_q <= w_data_q[P3_W-1:0];
    end
  end

  // read channel; pad level is sampled at the address handshake
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (addr_is(s_axi_araddr, ADDR_DATA)) begin
        s_axi_rdata <= {24'h0000_00, port_read}; // see R7
      end else if (addr_is(s_axi_araddr, ADDR_DIR)) begin
        s_axi_rdata <= {24'h0000_00, DIR_READ}; // see R10
      end else if (addr_is(s_axi_araddr, ADDR_P3_PU)) begin
        s_axi_rdata <= {24'h0000_00, p3_pu_en_q};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // rstn is part of the mode so that the edge that releases reset, when the pads still
  // hold their reset values, starts no check
  logic act_mode;
  assign act_mode = rstn && ((power_mode == MODE_ACTIVE) || (power_mode == MODE_SUBACTIVE));

  property p_pullup_rule;
    act_mode |=> p3_pullup_on == $past(~port_three_direction & p3_pu_en_q);
  endproperty
  a_pullup_rule: assert property (p_pullup_rule) else $error("pull-up mismatch"); // see R3

  property p_standby_high;
    rstn && power_mode == MODE_STANDBY |=>
      p3_pin_oe == $past(p3_pu_d) && p3_pin_out == p3_pin_oe;
  endproperty
  a_standby_high: assert property (p_standby_high) else $error("standby pad wrong"); // see R1 R16

  property p_sleep_hold;
    (power_mode == MODE_SLEEP) [*2] |-> $stable(p3_pin_oe) && $stable(p4_pin_oe);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep did not hold"); // see R1

  property p_reset_values;
    $rose(rstn) |-> p3_pu_en_q == 8'h00 && dir_q == 3'h0 && data_q == 3'h0;
  endproperty
  a_reset_values: assert property (@(posedge clk_sys) p_reset_values) // see R4
    else $error("bad reset values");

  property p_dir_reads_ones;
    s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, ADDR_DIR)
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_00ff;
  endproperty
  a_dir_reads_ones: assert property (p_dir_reads_ones) else $error("dir read not ones"); // see R10

  property p_data_read;
    s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, ADDR_DATA)
      |=> s_axi_rdata[7:4] == 4'hf && s_axi_rdata[3] == $past(p4_pin_in[3]) &&
          s_axi_rdata[2:0] == $past((dir_q & data_q) | (~dir_q & p4_pin_in[2:0]));
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read wrong"); // see R7 R17

  property p_tx_drive;
    act_mode && tx_sel |=> p4_pin_oe[2] && p4_pin_out[2] == $past(serial_two_tx_pin);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("tx pin not driven"); // see R13

  property p_rx_input;
    act_mode && rx_sel |=> !p4_pin_oe[1];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("rx pin driven"); // see R14

  property p_clk_in;
    act_mode && serial_two_clock_sel_high |=> !p4_pin_oe[0] &&
      serial_two_clock_in == $past(p4_pin_in[0]);
  endproperty
  a_clk_in: assert property (p_clk_in) else $error("clock input wrong"); // see R15

  property p_bit3_input;
    !p4_pin_oe[3];
  endproperty
  a_bit3_input: assert property (p_bit3_input) else $error("bit 3 driven"); // see R5

  c_write_dir: cover property (wr_fire && addr_is(aw_addr_q, ADDR_DIR));
  c_read_data: cover property (s_axi_rvalid && s_axi_rready);
  c_standby:   cover property (power_mode == MODE_STANDBY && |p3_pu_d);
  c_tx_mode:   cover property (act_mode && tx_sel);

endmodule // iop4_port

// ### dv/iop4_pads.sv
`timescale 1ns/1ps
// board around the port four pads: a pad the device drives shows its level,
// any other pad shows the level the board puts on it, never an unknown
module iop4_pads (
  // device side
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // board side
  input  wire logic [3:0] ext_lvl,
  output logic      [3:0] pin_lvl
);
  // per pad resolution; the board yields while the device drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule // iop4_pads

// ### dv/iop4_port_tb.sv
`timescale 1ns/1ps
module iop4_port_tb import iop4_pkg::*; ;
  typedef struct packed {
    logic [2:0] dir;
    logic [2:0] dat;
    logic [3:0] ext;
    logic [7:0] rd;
  } iop4_row_t;
  // clock, reset and bus
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb = 4'h1;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  iop4_mode_t        power_mode = MODE_ACTIVE;
  // serial and interrupt pin controls
  logic              serial_two_pin_select = 0, serial_two_tx_enable = 0, serial_two_tx_pin = 0;
  logic              serial_two_rx_enable = 0, serial_two_clock_sel_high = 0;
  logic              serial_two_clock_sel_low = 0, serial_two_sync_mode = 0;
  logic              serial_two_clock_out = 0, ext_interrupt_zero_select = 0;
  logic              serial_two_rx_pin, serial_two_clock_in, ext_interrupt_zero_in;
  // pads
  logic [3:0]        p4_pin_in, p4_pin_out, p4_pin_oe;
  logic [3:0]        ext_lvl = 4'he;
  logic [7:0]        port_three_direction = 8'h00, p3_func_out = 8'ha5;
  logic [7:0]        p3_pin_out, p3_pin_oe, p3_pullup_on;
  int                n_errors = 0, n_compared = 0;
  // ordinary cases: direction, latch, board levels, expected port read
  localparam iop4_row_t ROWS [4] = '{
    '{3'b000, 3'b111, 4'b1010, 8'hfa},
    '{3'b111, 3'b101, 4'b0000, 8'hf5},
    '{3'b101, 3'b011, 4'b1111, 8'hfb},
    '{3'b010, 3'b000, 4'b0101, 8'hf5}};

  always #4 clk_sys = ~clk_sys;

  iop4_port #(.FLASH_VARIANT(1'b1)) u_dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode, .serial_two_pin_select,
    .serial_two_tx_enable, .serial_two_rx_enable, .serial_two_clock_sel_high,
    .serial_two_clock_sel_low, .serial_two_sync_mode, .serial_two_tx_pin,
    .serial_two_clock_out, .serial_two_rx_pin, .serial_two_clock_in,
    .ext_interrupt_zero_select, .ext_interrupt_zero_in, .p4_pin_in, .p4_pin_out, .p4_pin_oe,
    .port_three_direction, .p3_func_out, .p3_pin_out, .p3_pin_oe, .p3_pullup_on);

  iop4_pads u_pads (.pin_out(p4_pin_out), .pin_oe(p4_pin_oe), .ext_lvl, .pin_lvl(p4_pin_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // address and data offered together, each dropped at the edge it is taken
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // pads lag their cause by one edge; wait two edges and look half a cycle after the second
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // {pin_select, tx_en, tx_pin, rx_en, sel_high, sel_low, sync, clock_out, irq_select}
  task automatic ser(input logic [8:0] v);
    @(posedge clk_sys);
    {serial_two_pin_select, serial_two_tx_enable, serial_two_tx_pin, serial_two_rx_enable,
     serial_two_clock_sel_high, serial_two_clock_sel_low, serial_two_sync_mode,
     serial_two_clock_out, ext_interrupt_zero_select} <= v;
    settle();
  endtask

  task automatic pm(input iop4_mode_t m);
    @(posedge clk_sys);
    power_mode <= m;
    settle();
  endtask

  // watchdog: the whole sequence needs under two hundred cycles
  initial begin
    #100000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    @(posedge clk_sys);
    #1;
    chk(p3_pullup_on, 8'h04, "reset pull-up");
    chk(p4_pin_oe, 4'h0, "reset p4 float");
    chk(p3_pin_oe, 8'h00, "reset p3 float");
    @(posedge clk_sys);
    rstn <= 1'b1;
    settle();
    chk(p3_pullup_on, 8'h00, "pull-ups after reset");
    chk(p4_pin_oe, 4'h0, "inputs after reset");
    axi_rd(ADDR_DIR);
    chk(rd, 32'h0000_00ff, "direction read");
    axi_rd(ADDR_DATA);
    chk(rd, 32'h0000_00fe, "pads read at reset");
    axi_wr(ADDR_DIR, 8'h07);
    axi_rd(ADDR_DATA);
    chk(rd, 32'h0000_00f8, "latch reset value");
    $display("test reset done");
    foreach (ROWS[i]) begin
      axi_wr(ADDR_DIR, {5'h00, ROWS[i].dir});
      axi_wr(ADDR_DATA, {5'h00, ROWS[i].dat});
      ext_lvl <= ROWS[i].ext;
      settle();
      chk(p4_pin_oe, {1'b0, ROWS[i].dir}, "row oe");
      chk(p4_pin_out & p4_pin_oe, {1'b0, ROWS[i].dir & ROWS[i].dat}, "row out");
      axi_rd(ADDR_DATA);
      chk(rd, {24'h00_0000, ROWS[i].rd}, "row read");
      axi_rd(ADDR_DIR);
      chk(rd, 32'h0000_00ff, "row direction read");
      $display("test row %0d done", i);
    end
    axi_wr(18'h0_0000, 8'h00);
    chk(rsp, RESP_SLVERR, "unmapped write");
    axi_rd(18'h0_0000);
    chk(rsp, RESP_SLVERR, "unmapped read");
    $display("test unmapped done");
    // serial functions over a pin set to output with latch zero
    axi_wr(ADDR_DIR, 8'h07);
    axi_wr(ADDR_DATA, 8'h00);
    ext_lvl <= 4'h0;
    ser(9'b1_1_1_1_1_0_0_0_1);
    chk(p4_pin_oe, 4'b0100, "tx rx clock-in oe");
    chk(p4_pin_out[2], 1'b1, "tx out");
    chk(serial_two_rx_pin, 1'b0, "rx pin");
    chk(serial_two_clock_in, 1'b0, "clock in");
    chk(ext_interrupt_zero_in, 1'b0, "irq in");
    axi_rd(ADDR_DATA);
    chk(rd[2], 1'b0, "latch over pad");
    ser(9'b1_0_1_1_0_1_0_1_0);
    chk(p4_pin_oe, 4'b0101, "clock out oe");
    chk(p4_pin_out & p4_pin_oe, 4'b0001, "clock out level");
    chk(ext_interrupt_zero_in, 1'b1, "irq deselected");
    ser(9'b0_0_0_0_0_0_1_1_0);
    chk(p4_pin_oe, 4'b0111, "sync clock oe");
    chk(p4_pin_out & p4_pin_oe, 4'b0001, "sync clock level");
    ser(9'h000);
    chk(p4_pin_out & p4_pin_oe, 4'b0000, "back to latch");
    $display("test serial done");
    // neighbour pull-ups and power modes
    @(posedge clk_sys);
    port_three_direction <= 8'h0f;
    axi_wr(ADDR_P3_PU, 8'hff);
    settle();
    chk(p3_pullup_on, 8'hf0, "pull-up gating");
    chk(p3_pin_out, 8'ha5, "active p3 out");
    chk(p3_pin_oe, 8'h0f, "active p3 oe");
    pm(MODE_SLEEP);
    axi_wr(ADDR_DIR, 8'h00);
    settle();
    chk(p4_pin_oe, 4'h7, "sleep holds");
    pm(MODE_STANDBY);
    chk(p4_pin_oe, 4'h0, "standby p4 float");
    chk(p3_pin_oe, 8'hf0, "standby pulled pins");
    chk(p3_pin_out & p3_pin_oe, 8'hf0, "standby high");
    pm(MODE_RESET);
    chk(p3_pin_oe, 8'h00, "reset mode float");
    chk(p3_pullup_on, 8'h04, "reset mode pull-up");
    pm(MODE_SUBACTIVE);
    chk(p4_pin_oe, 4'h0, "subactive follows direction");
    chk(p3_pin_oe, 8'h0f, "subactive p3 oe");
    $display("test power modes done");
    // a reset in mid-run must bring back the register reset values
    axi_wr(ADDR_DIR, 8'h07);
    axi_wr(ADDR_DATA, 8'h07);
    @(posedge clk_sys);
    rstn    <= 1'b0;
    ext_lvl <= 4'h8;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    settle();
    chk(p4_pin_oe, 4'h0, "mid-run reset inputs");
    chk(p3_pullup_on, 8'h00, "mid-run reset pull-ups");
    axi_wr(ADDR_DIR, 8'h07);
    axi_rd(ADDR_DATA);
    chk(rd, 32'h0000_00f8, "mid-run latch reset");
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule // iop4_port_tb
